// ==== rtl/cam_channel.v ====
// one compare/pwm channel: comparator, toggle and pwm waveform
`timescale 1ns/100ps
`include "cam_defs.vh"
module cam_channel (
	// clock and reset
	input  wire        mclk,
	input  wire        sys_rst,
	// shared counter
	input  wire        countTick,
	input  wire [15:0] baseCount,
	// mode controls
	input  wire        comparatorOn,
	input  wire        matchToggleOn,
	input  wire        pulseWidthOutOn,
	input  wire        outputInvert,
	input  wire [1:0]  resolutionSel,
	// compare values
	input  wire        ninthBitHi,
	input  wire        ninthBitLo,
	input  wire [7:0]  compareHiByte,
	input  wire [7:0]  compareLoByte,
	// events and pin
	output wire        matchEvent,
	output wire        reloadLow,
	output reg         pinOut
);

	reg        rawState;
	wire [1:0] pwmCmp;
	wire       match16;
	wire       copmMatch;
	wire       pwmActive;

	// returns {equal, less} of counter against compare value at a resolution
	function [1:0] resCompare;
		input [1:0]  res;
		input [15:0] cnt;
		input [7:0]  hiB;
		input [7:0]  loB;
		input        nLo;
		begin
			case (res)
				`CAM_RES_8: begin
					resCompare = {({1'b0, cnt[7:0]} == {nLo, loB}), ({1'b0, cnt[7:0]} < {nLo, loB})};
				end
				`CAM_RES_10: begin
					resCompare = {(cnt[9:0] == {hiB[1:0], loB}), (cnt[9:0] < {hiB[1:0], loB})};
				end
				`CAM_RES_12: begin
					resCompare = {(cnt[11:0] == {hiB[3:0], loB}), (cnt[11:0] < {hiB[3:0], loB})};
				end
				default: begin
					resCompare = {(cnt == {hiB, loB}), (cnt < {hiB, loB})};
				end
			endcase
		end
	endfunction

	assign pwmActive = comparatorOn & pulseWidthOutOn;
	assign pwmCmp    = resCompare(resolutionSel, baseCount, compareHiByte, compareLoByte, ninthBitLo);
	// plain 16-bit match, only with comparator on and pwm off
	assign match16   = countTick & comparatorOn & ~pulseWidthOutOn & (baseCount == {compareHiByte, compareLoByte});
	assign copmMatch = countTick & pwmActive & matchToggleOn & pwmCmp[1];
	assign matchEvent = match16;
	// low-byte wrap reloads the active 9-bit duty value
	assign reloadLow = countTick & pwmActive & (resolutionSel == `CAM_RES_8)
		& (baseCount[7:0] == `CAM_LOW_WRAP);

	// waveform state; untouched when the module is idle
	always @(posedge mclk) begin
		if (sys_rst) begin
			rawState <= 1'b0;
			pinOut   <= 1'b0;
		end else begin
			if ((match16 & matchToggleOn) | copmMatch) begin
				rawState <= ~rawState;
			end else if (countTick & pwmActive & ~matchToggleOn) begin
				rawState <= ~pwmCmp[0];
			end
			pinOut <= rawState ^ outputInvert;
		end
	end

endmodule // cam_channel

// ==== rtl/cam_ctl.v ====
// mode control and compare/capture registers of the eight counter array modules
//
// Summary of operation
// - capture on rising, falling or either pin edge per the two capture enables
// - modules 6 and 7 never capture; their rise-capture bit is reserved
// - modules 0-5 match sets their event flag in the counter control register
// - modules 6 and 7 match sets the flag in their auxiliary register
// - toggle control inverts the module pin on each match
// - pwm control drives the pin as pulse-width output, off when clear
// - comparator enable turns the module comparator on or off
// - interrupt request only while event flag and flag enable are both set
// - dead-time enable acts on modules 0, 2, 4 only in pair buffer mode
// - module 6 bit 7 enables 6/7 pair buffering when module 6 or 7 is in pwm or compare-pwm
// - each module holds low and high compare/capture bytes
// - extended register widens pwm duty to 0..100 percent in 1/256 steps
// - resolution bits pick 8, 10, 12 or 16 bit pwm width
// - auxiliary flag valid for modules 6, 7; hardware sets, software clears
// - invert bit inverts the compare/pwm result on the pin
// - auxiliary bits 1 and 0 are ninth bits of high and low bytes
// - mode, compare and auxiliary registers reset to zero
// - modules 0-5 flags set by match or capture, cleared only by software
// - 8-bit pwm low while {0,low count} below 9-bit low compare value
// - low count wrap reloads 9-bit low compare from 9-bit high compare
`timescale 1ns/100ps
`include "cam_defs.vh"
module cam_ctl (
	// clock and reset
	input  wire        mclk,
	input  wire        sys_rst,
	// special function register access
	input  wire [7:0]  sfrAddr,
	input  wire [3:0]  sfrPage,
	input  wire        sfrWr,
	input  wire        sfrRd,
	input  wire [7:0]  sfrWrData,
	output reg  [7:0]  sfrRdData,
	// shared base counter
	input  wire        countTick,
	input  wire [15:0] baseCount,
	// pair buffer enables for pairs 0/1, 2/3, 4/5
	input  wire [2:0]  firstPairBufferOn,
	// module pins
	input  wire [5:0]  moduleIoPinIn,
	output wire [7:0]  moduleIoPinOut,
	output reg  [7:0]  moduleIoPinOe,
	// status to the rest of the array
	output reg  [7:0]  moduleIrqReq,
	output reg  [2:0]  deadTimeActive,
	output reg         upperPairBufferActive
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg  [7:0] modeReg [0:7];
	reg  [7:0] loReg   [0:7];
	reg  [7:0] hiReg   [0:7];
	reg  [7:0] auxReg  [0:7];
	reg  [5:0] ccfLow;

	wire [5:0] riseEdge;
	wire [5:0] fallEdge;
	wire [7:0] matchEvent;
	wire [7:0] reloadLow;
	wire [7:0] captureEvent;
	wire [7:0] flagAll;
	wire [3:0] modeHit;
	wire [3:0] loHit;
	wire [3:0] hiHit;
	wire [3:0] auxHit;
	wire [7:0] auxWrData;
	integer    i;
	integer    j;

	// ----------------------------------------
	// address decode
	// ----------------------------------------

	// returns {valid, module index} for a register group base and page
	function [3:0] decodeModule;
		input [7:0] addr;
		input [7:0] base;
		input [3:0] page;
		reg   [7:0] offs;
		begin
			offs = addr - base;
			if (offs >= `CAM_ADDR_SPAN) begin
				decodeModule = 4'h0;
			end else if (offs >= `CAM_LOW_PAIR) begin
				decodeModule = {1'b1, offs[2:0]};
			end else if (page == `CAM_PAGE_LOWER) begin
				decodeModule = {1'b1, offs[2:0]};
			end else if (page == `CAM_PAGE_UPPER) begin
				decodeModule = {1'b1, offs[2:0] + `CAM_UPPER_OFFSET};
			end else begin
				decodeModule = 4'h0;
			end
		end
	endfunction

	assign modeHit = decodeModule(sfrAddr, `CAM_MODE_BASE, sfrPage);
	assign loHit   = decodeModule(sfrAddr, `CAM_LO_BASE, sfrPage);
	assign hiHit   = decodeModule(sfrAddr, `CAM_HI_BASE, sfrPage);
	assign auxHit  = decodeModule(sfrAddr, `CAM_AUX_BASE, sfrPage);

	// true when a decoded group hit names the given module
	function hitsModule;
		input [3:0] hit;
		input [2:0] idx;
		begin
			hitsModule = hit[3] & (hit[2:0] == idx);
		end
	endfunction

	// auxiliary write data with the reserved bits forced low
	assign auxWrData = sfrWrData & `CAM_AUX_RSV_MASK;

	// ----------------------------------------
	// capture events
	// ----------------------------------------

	cam_edge_det u_edge (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.pinIn    (moduleIoPinIn),
		.riseEdge (riseEdge),
		.fallEdge (fallEdge)
	);

	// edge qualified by each module's capture enables
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_cap
			assign captureEvent[g] = (riseEdge[g] & modeReg[g][`CAM_MODE_RISE])
				| (fallEdge[g] & modeReg[g][`CAM_MODE_FALL]);
		end
	endgenerate
	assign captureEvent[7:6] = 2'b00;

	// ----------------------------------------
	// compare/pwm channels
	// ----------------------------------------
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_chan
			cam_channel u_chan (
				.mclk            (mclk),
				.sys_rst         (sys_rst),
				.countTick       (countTick),
				.baseCount       (baseCount),
				.comparatorOn    (modeReg[g][`CAM_MODE_CMP]),
				.matchToggleOn   (modeReg[g][`CAM_MODE_TOGGLE]),
				.pulseWidthOutOn (modeReg[g][`CAM_MODE_PWM]),
				.outputInvert    (auxReg[g][`CAM_AUX_INV]),
				.resolutionSel   (auxReg[g][`CAM_AUX_RES_HI:`CAM_AUX_RES_LO]),
				.ninthBitHi      (auxReg[g][`CAM_AUX_NINTH_HI]),
				.ninthBitLo      (auxReg[g][`CAM_AUX_NINTH_LO]),
				.compareHiByte   (hiReg[g]),
				.compareLoByte   (loReg[g]),
				.matchEvent      (matchEvent[g]),
				.reloadLow       (reloadLow[g]),
				.pinOut          (moduleIoPinOut[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// register writes and hardware updates
	// ----------------------------------------

	// software writes; capture, reload and flag set win over a same-cycle write
	always @(posedge mclk) begin
		if (sys_rst) begin
			for (i = 0; i < 8; i = i + 1) begin
				modeReg[i] <= `CAM_REG_RESET;
				loReg[i]   <= `CAM_REG_RESET;
				hiReg[i]   <= `CAM_REG_RESET;
				auxReg[i]  <= `CAM_REG_RESET;
			end
			ccfLow <= 6'h00;
		end else begin
			for (i = 0; i < 8; i = i + 1) begin
				// mode register; reserved bits of modules 6 and 7 stay zero
				if (sfrWr && hitsModule(modeHit, i[2:0])) begin
					if (i == 6) begin
						modeReg[i] <= sfrWrData & 8'hDF;
					end else if (i == 7) begin
						modeReg[i] <= sfrWrData & 8'h5F;
					end else begin
						modeReg[i] <= sfrWrData;
					end
				end
				// compare bytes: capture loads the shared count
				if (captureEvent[i]) begin
					loReg[i] <= baseCount[7:0];
					hiReg[i] <= baseCount[15:8];
				end else begin
					if (reloadLow[i]) begin
						loReg[i] <= hiReg[i];
					end else if (sfrWr && hitsModule(loHit, i[2:0])) begin
						loReg[i] <= sfrWrData;
					end
					if (sfrWr && hitsModule(hiHit, i[2:0])) begin
						hiReg[i] <= sfrWrData;
					end
				end
				// auxiliary register; reserved bits held at zero
				if (sfrWr && hitsModule(auxHit, i[2:0])) begin
					auxReg[i][7:4] <= auxWrData[7:4];
					auxReg[i][2:0] <= sfrWrData[2:0];
				end
				if (reloadLow[i]) begin
					auxReg[i][`CAM_AUX_NINTH_LO] <= auxReg[i][`CAM_AUX_NINTH_HI];
				end
				// upper module flags: set on match, software clears by writing zero
				if (i >= 6) begin
					if (matchEvent[i] & modeReg[i][`CAM_MODE_MATCH]) begin
						auxReg[i][`CAM_AUX_FLAG] <= 1'b1;
					end else if (sfrWr && hitsModule(auxHit, i[2:0]) && !sfrWrData[`CAM_AUX_FLAG]) begin
						auxReg[i][`CAM_AUX_FLAG] <= 1'b0;
					end
				end else begin
					auxReg[i][`CAM_AUX_FLAG] <= 1'b0;
				end
			end
			// lower module flags in counter control; a set beats a clear
			if (sfrWr && (sfrAddr == `CAM_CTL_ADDR)) begin
				ccfLow <= (ccfLow & sfrWrData[5:0]) | captureEvent[5:0]
					| (matchEvent[5:0] & matchEnables(1'b0));
			end else begin
				ccfLow <= ccfLow | captureEvent[5:0] | (matchEvent[5:0] & matchEnables(1'b0));
			end
		end
	end

	// match-control bits of modules 0 to 5
	function [5:0] matchEnables;
		input dummy;
		integer k;
		begin
			for (k = 0; k < 6; k = k + 1) begin
				matchEnables[k] = modeReg[k][`CAM_MODE_MATCH];
			end
		end
	endfunction

	assign flagAll = {auxReg[7][`CAM_AUX_FLAG], auxReg[6][`CAM_AUX_FLAG], ccfLow};

	// ----------------------------------------
	// status outputs
	// ----------------------------------------

	// interrupt requests, pin enables, dead-time and pair buffering
	always @(posedge mclk) begin
		if (sys_rst) begin
			moduleIrqReq          <= 8'h00;
			moduleIoPinOe         <= 8'h00;
			deadTimeActive        <= 3'h0;
			upperPairBufferActive <= 1'b0;
		end else begin
			for (j = 0; j < 8; j = j + 1) begin
				moduleIrqReq[j]  <= flagAll[j] & modeReg[j][`CAM_MODE_IRQ];
				moduleIoPinOe[j] <= modeReg[j][`CAM_MODE_CMP]
					& (modeReg[j][`CAM_MODE_PWM] | modeReg[j][`CAM_MODE_TOGGLE]);
			end
			for (j = 0; j < 3; j = j + 1) begin
				deadTimeActive[j] <= modeReg[2 * j][`CAM_MODE_DEAD] & firstPairBufferOn[j]
					& modeReg[2 * j][`CAM_MODE_PWM];
			end
			upperPairBufferActive <= modeReg[6][`CAM_MODE_BUFFER]
				& (modeReg[6][`CAM_MODE_PWM] | modeReg[7][`CAM_MODE_PWM]);
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------

	// registered read data, zero for unmapped addresses
	always @(posedge mclk) begin
		if (sys_rst) begin
			sfrRdData <= 8'h00;
		end else if (sfrRd) begin
			if (sfrAddr == `CAM_CTL_ADDR) begin
				sfrRdData <= {2'b00, ccfLow};
			end else if (modeHit[3]) begin
				sfrRdData <= modeReg[modeHit[2:0]];
			end else if (loHit[3]) begin
				sfrRdData <= loReg[loHit[2:0]];
			end else if (hiHit[3]) begin
				sfrRdData <= hiReg[hiHit[2:0]];
			end else if (auxHit[3]) begin
				sfrRdData <= auxReg[auxHit[2:0]];
			end else begin
				sfrRdData <= 8'h00;
			end
		end
	end

endmodule // cam_ctl

// ==== rtl/cam_defs.vh ====
// register addresses, field positions and reset values of the counter array module control
`ifndef CAM_DEFS_VH
`define CAM_DEFS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define CAM_CTL_ADDR     8'hD8
`define CAM_MODE_BASE    8'hDA
`define CAM_LO_BASE      8'hEA
`define CAM_AUX_BASE     8'hF2
`define CAM_HI_BASE      8'hFA
`define CAM_ADDR_SPAN    8'h06
`define CAM_LOW_PAIR     8'h02
`define CAM_UPPER_OFFSET 3'h6
`define CAM_PAGE_LOWER   4'h0
`define CAM_PAGE_UPPER   4'h1

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define CAM_MODE_DEAD    7
`define CAM_MODE_BUFFER  7
`define CAM_MODE_CMP     6
`define CAM_MODE_RISE    5
`define CAM_MODE_FALL    4
`define CAM_MODE_MATCH   3
`define CAM_MODE_TOGGLE  2
`define CAM_MODE_PWM     1
`define CAM_MODE_IRQ     0

// ----------------------------------------
// auxiliary width register fields
// ----------------------------------------
`define CAM_AUX_RES_HI   7
`define CAM_AUX_RES_LO   6
`define CAM_AUX_RSV_MASK 8'hCF
`define CAM_AUX_FLAG     3
`define CAM_AUX_INV      2
`define CAM_AUX_NINTH_HI 1
`define CAM_AUX_NINTH_LO 0

// ----------------------------------------
// resolution codes and reset values
// ----------------------------------------
`define CAM_RES_8        2'h0
`define CAM_RES_10       2'h1
`define CAM_RES_12       2'h2
`define CAM_RES_16       2'h3
`define CAM_LOW_WRAP     8'hFF
`define CAM_REG_RESET    8'h00

`endif

// ==== rtl/cam_edge_det.v ====
// edge detector for the capture-capable module pins
`timescale 1ns/100ps
module cam_edge_det (
	// clock and reset
	input  wire       mclk,
	input  wire       sys_rst,
	// pin levels
	input  wire [5:0] pinIn,
	// edge pulses
	output reg  [5:0] riseEdge,
	output reg  [5:0] fallEdge
);

	reg [5:0] prevLevel;

	// remember last level and flag transitions
	always @(posedge mclk) begin
		if (sys_rst) begin
			prevLevel <= 6'h00;
			riseEdge  <= 6'h00;
			fallEdge  <= 6'h00;
		end else begin
			prevLevel <= pinIn;
			riseEdge  <= pinIn & ~prevLevel;
			fallEdge  <= ~pinIn & prevLevel;
		end
	end

endmodule // cam_edge_det

// ==== tb/cam_ctl_bench.sv ====
// self-checking bench of the counter array module control
`timescale 1ns/100ps
module cam_ctl_bench;
	localparam [31:0] BASES   = 32'hFAF2EADA;
	localparam [23:0] CAPM    = 24'h311121;
	localparam [63:0] RES_THR = 64'h8000080001000080;
	reg         mclk;
	reg         sys_rst;
	reg  [7:0]  sfrAddr;
	reg  [3:0]  sfrPage;
	reg         sfrWr;
	reg         sfrRd;
	reg  [7:0]  sfrWrData;
	wire [7:0]  sfrRdData;
	reg         countTick;
	reg  [15:0] baseCount;
	reg  [2:0]  firstPairBufferOn;
	reg  [5:0]  pinLevel;
	wire [5:0]  moduleIoPinIn;
	wire [7:0]  moduleIoPinOut;
	wire [7:0]  moduleIoPinOe;
	wire [7:0]  moduleIrqReq;
	wire [2:0]  deadTimeActive;
	wire        upperPairBufferActive;
	integer     err_total;
	integer     n_checks;
	integer     i;
	integer     k;
	reg  [7:0]  m;
	reg  [7:0]  v;
	reg  [7:0]  expLo;
	reg  [15:0] thr;

	cam_ctl cam_ctl_i (.mclk(mclk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWr(sfrWr),
		.sfrRd(sfrRd), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .countTick(countTick), .baseCount(baseCount),
		.firstPairBufferOn(firstPairBufferOn), .moduleIoPinIn(moduleIoPinIn), .moduleIoPinOut(moduleIoPinOut),
		.moduleIoPinOe(moduleIoPinOe), .moduleIrqReq(moduleIrqReq), .deadTimeActive(deadTimeActive),
		.upperPairBufferActive(upperPairBufferActive));
	cam_pin_model cam_pin_model_i (.pinLevel(pinLevel), .moduleIoPinOut(moduleIoPinOut),
		.moduleIoPinOe(moduleIoPinOe), .moduleIoPinIn(moduleIoPinIn));

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task chk(input [127:0] nm, input [7:0] exp, input [7:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task wr(input [7:0] a, input [3:0] p, input [7:0] d);
		begin
			@(negedge mclk);
			sfrAddr = a;
			sfrPage = p;
			sfrWrData = d;
			sfrWr = 1'b1;
			@(negedge mclk);
			sfrWr = 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [3:0] p, input [7:0] e);
		begin
			@(negedge mclk);
			sfrAddr = a;
			sfrPage = p;
			sfrRd = 1'b1;
			@(negedge mclk);
			sfrRd = 1'b0;
			chk("register read", e, sfrRdData);
		end
	endtask
	task tick(input [15:0] c);
		begin
			@(negedge mclk);
			baseCount = c;
			countTick = 1'b1;
			@(negedge mclk);
			countTick = 1'b0;
		end
	endtask
	task pinChk(input integer n, input e);
		begin
			repeat (2) @(negedge mclk);
			chk("module pin", {7'h00, e}, {7'h00, moduleIoPinOut[n]});
		end
	endtask
	task pinSet(input lvl, input [7:0] lo);
		begin
			@(negedge mclk);
			baseCount = {8'hA5, lo};
			pinLevel[1] = lvl;
			repeat (4) @(negedge mclk);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask

	// clock of 40 ns
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// watchdog against a hung sequence
	initial begin
		#400000;
		err_total = err_total + 1;
		finish_test;
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		err_total = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		sfrAddr = 8'h00;
		sfrPage = 4'h0;
		sfrWr = 1'b0;
		sfrRd = 1'b0;
		sfrWrData = 8'h00;
		countTick = 1'b0;
		baseCount = 16'h0000;
		firstPairBufferOn = 3'h0;
		pinLevel = 6'h00;
		repeat (5) @(negedge mclk);
		sys_rst = 1'b0;
		// reset values and an idle tick on matching counts
		for (i = 0; i < 4; i = i + 1)
			for (k = 0; k < 8; k = k + 1)
				rd(BASES[8*i +: 8] + ((k < 6) ? k[7:0] : k[7:0] - 8'h06), (k < 6) ? 4'h0 : 4'h1, 8'h00);
		tick(16'h0000);
		rd(8'hD8, 4'h0, 8'h00);
		chk("pin enables", 8'h00, moduleIoPinOe);
		// reserved bits and page mapping
		wr(8'hDA, 4'h1, 8'hFF);
		rd(8'hDA, 4'h1, 8'hDF);
		wr(8'hDB, 4'h1, 8'hFF);
		rd(8'hDB, 4'h1, 8'h5F);
		rd(8'hDA, 4'h0, 8'h00);
		rd(8'hDA, 4'h2, 8'h00);
		wr(8'hDA, 4'h1, 8'h00);
		wr(8'hDB, 4'h1, 8'h00);
		wr(8'hF7, 4'h0, 8'hCF);
		rd(8'hF7, 4'h0, 8'hC7);
		wr(8'hF7, 4'h0, 8'h00);
		wr(8'hDC, 4'h5, 8'h01);
		rd(8'hDC, 4'h0, 8'h01);
		// capture on each edge selection of module 1
		v = 8'h11;
		expLo = 8'h00;
		for (i = 0; i < 3; i = i + 1) begin
			m = CAPM[8*i +: 8];
			wr(8'hDB, 4'h0, m);
			pinSet(1'b1, v);
			if (m[5]) expLo = v;
			rd(8'hEB, 4'h0, expLo);
			v = v + 8'h11;
			pinSet(1'b0, v);
			if (m[4]) expLo = v;
			rd(8'hEB, 4'h0, expLo);
			v = v + 8'h11;
		end
		rd(8'hFB, 4'h0, 8'hA5);
		rd(8'hD8, 4'h0, 8'h02);
		chk("irq request", 8'h02, moduleIrqReq);
		wr(8'hDB, 4'h0, 8'h30);
		repeat (2) @(negedge mclk);
		chk("irq request", 8'h00, moduleIrqReq);
		wr(8'hD8, 4'h0, 8'hFF);
		rd(8'hD8, 4'h0, 8'h02);
		wr(8'hD8, 4'h0, 8'h00);
		rd(8'hD8, 4'h0, 8'h00);
		// compare, toggle, invert and comparator off on module 2
		wr(8'hEC, 4'h0, 8'h10);
		wr(8'hFC, 4'h0, 8'h20);
		wr(8'hDC, 4'h0, 8'h4D);
		tick(16'h2011);
		rd(8'hD8, 4'h0, 8'h00);
		tick(16'h2010);
		pinChk(2, 1'b1);
		rd(8'hD8, 4'h0, 8'h04);
		chk("irq request", 8'h04, moduleIrqReq);
		wr(8'hF4, 4'h0, 8'h04);
		pinChk(2, 1'b0);
		wr(8'hD8, 4'h0, 8'h00);
		wr(8'hDC, 4'h0, 8'h0D);
		tick(16'h2010);
		rd(8'hD8, 4'h0, 8'h00);
		// match flag of module 6 in its aux register
		wr(8'hEA, 4'h1, 8'h05);
		wr(8'hDA, 4'h1, 8'h48);
		tick(16'h0005);
		rd(8'hF2, 4'h1, 8'h08);
		rd(8'hD8, 4'h0, 8'h00);
		wr(8'hF2, 4'h1, 8'h00);
		rd(8'hF2, 4'h1, 8'h00);
		wr(8'hDA, 4'h1, 8'h00);
		// 8-bit pwm, reload at low wrap and ninth bits on module 3
		wr(8'hFD, 4'h0, 8'h40);
		wr(8'hED, 4'h0, 8'h40);
		wr(8'hDD, 4'h0, 8'h42);
		tick(16'h0010);
		pinChk(3, 1'b0);
		tick(16'h0040);
		pinChk(3, 1'b1);
		wr(8'hFD, 4'h0, 8'hC0);
		tick(16'h00FF);
		rd(8'hED, 4'h0, 8'hC0);
		tick(16'h0050);
		pinChk(3, 1'b0);
		wr(8'hF5, 4'h0, 8'h02);
		wr(8'hFD, 4'h0, 8'h00);
		tick(16'h00FF);
		rd(8'hF5, 4'h0, 8'h03);
		tick(16'h00FE);
		pinChk(3, 1'b0);
		// each resolution on module 4
		wr(8'hDE, 4'h0, 8'h42);
		for (i = 0; i < 4; i = i + 1) begin
			thr = RES_THR[16*i +: 16];
			wr(8'hF6, 4'h0, {i[1:0], 6'h00});
			wr(8'hFE, 4'h0, thr[15:8]);
			wr(8'hEE, 4'h0, thr[7:0]);
			tick(thr - 16'h0001);
			pinChk(4, 1'b0);
			tick(thr);
			pinChk(4, 1'b1);
		end
		// dead time and pair buffer status
		firstPairBufferOn = 3'h1;
		wr(8'hDA, 4'h0, 8'hC2);
		repeat (2) @(negedge mclk);
		chk("dead time", 8'h01, {5'h00, deadTimeActive});
		chk("pin enable", 8'h01, {7'h00, moduleIoPinOe[0]});
		firstPairBufferOn = 3'h0;
		repeat (2) @(negedge mclk);
		chk("dead time", 8'h00, {5'h00, deadTimeActive});
		wr(8'hDA, 4'h1, 8'h82);
		repeat (2) @(negedge mclk);
		chk("upper buffer", 8'h01, {7'h00, upperPairBufferActive});
		wr(8'hDA, 4'h1, 8'h80);
		repeat (2) @(negedge mclk);
		chk("upper buffer", 8'h00, {7'h00, upperPairBufferActive});
		finish_test;
	end
endmodule // cam_ctl_bench

// ==== tb/cam_ctl_sva.sv ====
// assertions on the ports of the counter array module control
`timescale 1ns/100ps
module cam_ctl_sva (
	// clock and reset
	input wire       mclk,
	input wire       sys_rst,
	// register access
	input wire [7:0] sfrAddr,
	input wire [3:0] sfrPage,
	input wire       sfrWr,
	input wire       sfrRd,
	input wire [7:0] sfrWrData,
	input wire [7:0] sfrRdData,
	// pair enables and status
	input wire [2:0] firstPairBufferOn,
	input wire [7:0] moduleIoPinOe,
	input wire [7:0] moduleIrqReq,
	input wire [2:0] deadTimeActive,
	input wire       upperPairBufferActive
);
	reg [7:0] mode0;
	reg [7:0] mode1;
	reg [7:0] mode6;
	reg [7:0] mode7;

	// shadow copies of the mode registers that the status outputs follow
	always @(posedge mclk) begin
		if (sys_rst) begin
			mode0 <= 8'h00;
			mode1 <= 8'h00;
			mode6 <= 8'h00;
			mode7 <= 8'h00;
		end else if (sfrWr) begin
			if (sfrAddr == 8'hDA && sfrPage == 4'h0) mode0 <= sfrWrData;
			if (sfrAddr == 8'hDB && sfrPage == 4'h0) mode1 <= sfrWrData;
			if (sfrAddr == 8'hDA && sfrPage == 4'h1) mode6 <= sfrWrData;
			if (sfrAddr == 8'hDB && sfrPage == 4'h1) mode7 <= sfrWrData;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------
	// port relations
	// ----------------------------------------
	chk_rst_zero: assert property (disable iff (1'b0) sys_rst |=> moduleIoPinOe == 8'h00 && moduleIrqReq == 8'h00)
		else $error("outputs not cleared by reset");
	chk_page_gap: assert property (sfrRd && sfrPage == 4'h2 && sfrAddr == 8'hDA |=> sfrRdData == 8'h00)
		else $error("unmapped page read not zero");
	chk_mode6_rsv: assert property (sfrRd && sfrPage == 4'h1 && sfrAddr == 8'hDA |=> !sfrRdData[5])
		else $error("module 6 capture bit reads set");
	chk_aux_rsv: assert property (sfrRd && sfrAddr >= 8'hF2 && sfrAddr <= 8'hF7 |=> sfrRdData[5:4] == 2'h0)
		else $error("aux reserved bits read set");
	chk_irq_gate: assert property (!mode0[0] |=> !moduleIrqReq[0])
		else $error("irq raised with enable clear");
	chk_irq_gate_one: assert property (!mode1[0] |=> !moduleIrqReq[1])
		else $error("module 1 irq raised with enable clear");
	chk_oe_on: assert property (mode0[6] && (mode0[1] || mode0[2]) |=> moduleIoPinOe[0])
		else $error("pin not driven in output mode");
	chk_idle_quiet: assert property (mode0[6:1] == 6'h00 |=> !moduleIoPinOe[0])
		else $error("idle module drives its pin");
	chk_dead_time: assert property (1'b1 |=> deadTimeActive[0] == $past(mode0[7] && firstPairBufferOn[0] && mode0[1]))
		else $error("dead time status wrong");
	chk_upper_buf: assert property (1'b1 |=> upperPairBufferActive == $past(mode6[7] && (mode6[1] || mode7[1])))
		else $error("upper pair buffer status wrong");
endmodule // cam_ctl_sva

bind cam_ctl cam_ctl_sva cam_ctl_sva_i (.mclk(mclk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrPage(sfrPage),
	.sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
	.firstPairBufferOn(firstPairBufferOn), .moduleIoPinOe(moduleIoPinOe), .moduleIrqReq(moduleIrqReq),
	.deadTimeActive(deadTimeActive), .upperPairBufferActive(upperPairBufferActive));

// ==== tb/cam_pin_model.sv ====
// model of the external module pins seen by the capture inputs
`timescale 1ns/100ps
module cam_pin_model (
	// levels applied from outside
	input wire [5:0]  pinLevel,
	// device drive
	input wire [7:0]  moduleIoPinOut,
	input wire [7:0]  moduleIoPinOe,
	// level seen back at the device
	output wire [5:0] moduleIoPinIn
);
	// a driven pin reads its own drive, a released pin the outside level
	assign moduleIoPinIn = (moduleIoPinOe[5:0] & moduleIoPinOut[5:0]) | (~moduleIoPinOe[5:0] & pinLevel);
endmodule // cam_pin_model
